//--- design/dior_top.sv
// Dual-rate and single-rate pad registers with a pair FIFO toward the fabric.
// Overview of operation
// RQ1: Single-rate register offers async clear, async preset, sync reset, sync set, with enable.
// RQ2: The outside configuration keeps data input inversion at zero; none is built.
// RQ3: Input register has split, aligned and aligned-pipelined modes; split is default.
// RQ4: Split mode: rise sample shown on rise_out, fall sample on fall_out.
// RQ5: Aligned mode: both outputs update on rise; first pair has undefined fall.
// RQ6: Aligned-pipelined mode shows each rise and fall pair together on one rise.
// RQ7: Aligned-pipelined adds exactly one rise cycle over aligned, pairing samples zero, one.
// RQ8: Input reset clears at once; release happens on a capture clock edge.
// RQ9: Main clock local inversion set to 1 inverts the main capture clock.
// RQ10: Second clock acts as inverted clock when both inversion settings are zero.
// RQ11: Outside source feeds second clock same buffer if inverted, else through inverter.
// RQ12: Output register derives its half-period select from the clock itself.
// RQ13: Output register samples both fabric data inputs together on rising edge.
// RQ14: First data drives pad during clock high, second during clock low.
// RQ15: The tristate control path has the same dual-rate output behaviour.
// RQ16: Output set/reset forces the reset value onto the pad immediately.
// RQ17: After set/reset, reset value holds four clock cycles before data resumes.
// RQ18: Reset output value is one configurable bit selecting the post-reset pad level.

// Small synchronous FIFO with valid and ready on both sides.
module dior_fifo #(
    parameter int unsigned WIDTH = 2,
    parameter int unsigned DEPTH = 8
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];

    // Storage is not reset; only pointers and count carry control state.
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers wrap naturally because the depth is a power of two.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= push ? wr_q + 1'b1 : wr_q;
            rd_q <= pop ? rd_q + 1'b1 : rd_q;
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule // dior_fifo

module dior_top (
    input wire logic mclk,
    input wire logic resetn,
    output logic ddr_clk_out,
    input wire logic main_clk_local_invert,
    input wire logic second_clk_local_invert,
    input wire dior_pkg::dior_edge_mode_t edge_mode,
    input wire logic pad_in,
    input wire logic in_reg_reset,
    output logic rise_out,
    output logic fall_out,
    output dior_pkg::dior_pair_t pair_data,
    output logic pair_valid,
    input wire logic pair_ready,
    output logic pair_in_ready,
    input wire dior_pkg::dior_ff_variant_t sdr_variant,
    input wire logic sdr_ce,
    input wire logic sdr_sr,
    input wire logic sdr_pad_in,
    output logic sdr_q,
    input wire dior_pkg::dior_halves_t out_data,
    input wire dior_pkg::dior_halves_t out_drive_en,
    input wire logic output_set_reset,
    input wire logic reset_output_value,
    input wire logic reset_oe_value,
    output logic pad_out,
    output logic pad_oe
);
    import dior_pkg::*;

    logic ddr_clk_q;
    logic [DIOR_SYNC_STAGES-1:0] din_sync_q;
    logic din_f_q;
    logic [DIOR_SYNC_STAGES-1:0] sdr_sync_q;
    logic sdr_f_q;
    logic in_rst_n_q;
    logic f_cap_q;
    logic r_prev_q;
    logic rise_out_q;
    logic fall_out_q;
    logic push_q;
    logic sdr_clr_q;
    logic sdr_pre_q;
    dior_halves_t data_q;
    dior_halves_t oe_q;
    logic pad_q;
    logic oe_q_pad;
    logic [2:0] hold_q;

    // The capture clock is mclk divided by two; each mclk cycle is one half period.
    wire next_level = ~ddr_clk_q;
    wire c_eff = next_level ^ main_clk_local_invert; // [RQ9]
    // Second clock source as the outside wiring gives it, then its own local inversion.
    wire cb_src = second_clk_local_invert ? next_level : ~next_level; // [RQ11]
    wire cb_eff = cb_src ^ second_clk_local_invert; // [RQ10]
    wire rise_en = c_eff;
    wire fall_en = cb_eff;
    assign ddr_clk_out = ddr_clk_q;

    // Divider for the dual-rate clock.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ddr_clk_q <= 1'b0;
        end else begin
            ddr_clk_q <= next_level;
        end
    end

    // Pad inputs pass three flops; a change counts once the last two agree.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            din_sync_q <= '0;
            din_f_q <= 1'b0;
            sdr_sync_q <= '0;
            sdr_f_q <= 1'b0;
        end else begin
            din_sync_q <= {din_sync_q[DIOR_SYNC_STAGES-2:0], pad_in};
            sdr_sync_q <= {sdr_sync_q[DIOR_SYNC_STAGES-2:0], sdr_pad_in};
            if (din_sync_q[2] == din_sync_q[1]) begin
                din_f_q <= din_sync_q[2]; // Taken as is, never inverted. [RQ2]
            end
            if (sdr_sync_q[2] == sdr_sync_q[1]) begin
                sdr_f_q <= sdr_sync_q[2];
            end
        end
    end

    // Input reset: clears at once, released only on a capture edge.
    always_ff @(posedge mclk or negedge resetn or posedge in_reg_reset) begin
        if (!resetn) begin
            in_rst_n_q <= 1'b0;
        end else if (in_reg_reset) begin
            in_rst_n_q <= 1'b0; // [RQ8]
        end else if (rise_en || fall_en) begin
            in_rst_n_q <= 1'b1; // [RQ8]
        end
    end

    // Capture and alignment; the mode picks what each rise edge presents.
    always_ff @(posedge mclk or negedge in_rst_n_q) begin
        if (!in_rst_n_q) begin
            f_cap_q <= 1'b0; // [RQ8]
            r_prev_q <= 1'b0;
            rise_out_q <= 1'b0;
            fall_out_q <= 1'b0;
            push_q <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (fall_en) begin
                f_cap_q <= din_f_q;
            end
            if (rise_en) begin
                r_prev_q <= din_f_q;
            end
            case (edge_mode) // [RQ3]
                split_edge_mode: begin
                    if (rise_en) begin
                        rise_out_q <= din_f_q; // [RQ4]
                        push_q <= 1'b1;
                    end
                    if (fall_en) begin
                        fall_out_q <= din_f_q; // [RQ4]
                    end
                end
                aligned_edge_mode: begin
                    if (rise_en) begin
                        rise_out_q <= din_f_q; // [RQ5]
                        fall_out_q <= f_cap_q; // [RQ5]
                        push_q <= 1'b1;
                    end
                end
                aligned_pipelined_mode: begin
                    if (rise_en) begin
                        rise_out_q <= r_prev_q; // [RQ6] [RQ7]
                        fall_out_q <= f_cap_q; // [RQ6]
                        push_q <= 1'b1;
                    end
                end
                default: begin
                    push_q <= 1'b0;
                end
            endcase
        end
    end
    assign rise_out = rise_out_q;
    assign fall_out = fall_out_q;

    // The pad cannot be stalled, so fullness is reported; pairs then are lost.
    dior_fifo #(.WIDTH(DIOR_FIFO_WIDTH), .DEPTH(DIOR_FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .resetn(resetn),
        .in_data({rise_out_q, fall_out_q}),
        .in_valid(push_q),
        .in_ready(pair_in_ready),
        .out_data(pair_data),
        .out_valid(pair_valid),
        .out_ready(pair_ready)
    );

    // Single-rate flops: one with async clear, one with async preset.
    wire sdr_async_clr = sdr_sr && (sdr_variant == ff_async_clear);
    wire sdr_async_pre = sdr_sr && (sdr_variant == ff_async_preset);
    wire sdr_sync_rst = sdr_sr && (sdr_variant == ff_sync_reset);
    wire sdr_sync_set = sdr_sr && (sdr_variant == ff_sync_set);
    always_ff @(posedge mclk or negedge resetn or posedge sdr_async_clr) begin
        if (!resetn) begin
            sdr_clr_q <= 1'b0;
        end else if (sdr_async_clr) begin
            sdr_clr_q <= 1'b0; // [RQ1]
        end else if (sdr_sync_rst) begin
            sdr_clr_q <= 1'b0; // [RQ1]
        end else if (sdr_sync_set) begin
            sdr_clr_q <= 1'b1; // [RQ1]
        end else if (sdr_ce) begin
            sdr_clr_q <= sdr_f_q;
        end
    end
    always_ff @(posedge mclk or negedge resetn or posedge sdr_async_pre) begin
        if (!resetn) begin
            sdr_pre_q <= 1'b1;
        end else if (sdr_async_pre) begin
            sdr_pre_q <= 1'b1; // [RQ1]
        end else if (sdr_ce) begin
            sdr_pre_q <= sdr_f_q;
        end
    end
    assign sdr_q = (sdr_variant == ff_async_preset) ? sdr_pre_q : sdr_clr_q;

    // Set/reset hold counter: loaded at once, counts rise edges once released.
    always_ff @(posedge mclk or negedge resetn or posedge output_set_reset) begin
        if (!resetn) begin
            hold_q <= DIOR_HOLD_CYCLES;
        end else if (output_set_reset) begin
            hold_q <= DIOR_HOLD_CYCLES; // [RQ17]
        end else if (next_level && hold_q != DIOR_HOLD_ZERO) begin
            hold_q <= hold_q - DIOR_HOLD_STEP; // [RQ17]
        end
    end
    wire holding = output_set_reset || (hold_q != DIOR_HOLD_ZERO);

    // Sampled at the plain rise edge; the input clock inversion must not move the pad phase.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            data_q <= '0;
            oe_q <= '0;
            pad_q <= 1'b0;
            oe_q_pad <= 1'b0;
        end else if (next_level) begin
            data_q <= out_data; // [RQ13]
            oe_q <= out_drive_en; // [RQ15]
            pad_q <= out_data.first_half; // [RQ14]
            oe_q_pad <= out_drive_en.first_half; // [RQ15]
        end else begin
            pad_q <= data_q.second_half; // Select follows the clock. [RQ12] [RQ14]
            oe_q_pad <= oe_q.second_half; // [RQ15]
        end
    end

    // The forced value bypasses the flops so set/reset acts without a clock.
    assign pad_out = holding ? reset_output_value : pad_q; // [RQ16] [RQ18]
    assign pad_oe = holding ? reset_oe_value : oe_q_pad; // [RQ16]

    default clocking cb_main @(posedge mclk); endclocking
    default disable iff (!resetn);

    property p_split_rise;
        disable iff (!in_rst_n_q) rise_en && edge_mode == split_edge_mode && !in_reg_reset
            |=> rise_out_q == $past(din_f_q);
    endproperty
    a_split_rise: assert property (p_split_rise) else $error("split rise wrong"); // [RQ4]
    property p_split_fall;
        disable iff (!in_rst_n_q) fall_en && edge_mode == split_edge_mode && !in_reg_reset
            |=> fall_out_q == $past(din_f_q);
    endproperty
    a_split_fall: assert property (p_split_fall) else $error("split fall wrong"); // [RQ4]
    property p_aligned;
        disable iff (!in_rst_n_q) rise_en && edge_mode == aligned_edge_mode && !in_reg_reset
            |=> fall_out_q == $past(f_cap_q) && rise_out_q == $past(din_f_q);
    endproperty
    a_aligned: assert property (p_aligned) else $error("aligned pair wrong"); // [RQ5]
    property p_pipelined;
        disable iff (!in_rst_n_q) rise_en && edge_mode == aligned_pipelined_mode && !in_reg_reset
            |=> rise_out_q == $past(din_f_q, 3);
    endproperty
    a_pipelined: assert property (p_pipelined) else $error("pipelined lag wrong"); // [RQ7]
    property p_in_reset;
        in_reg_reset |-> !rise_out_q && !fall_out_q;
    endproperty
    a_in_reset: assert property (p_in_reset) else $error("input reset not clear"); // [RQ8]
    property p_force;
        output_set_reset |-> pad_out == reset_output_value;
    endproperty
    a_force: assert property (p_force) else $error("pad not forced"); // [RQ16]
    property p_hold_len;
        $fell(output_set_reset) |-> holding [*4];
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("hold too short"); // [RQ17]
    property p_first_half;
        !holding && ddr_clk_q |-> pad_out == data_q.first_half;
    endproperty
    a_first_half: assert property (p_first_half) else $error("first half wrong"); // [RQ14]
    property p_edges;
        !main_clk_local_invert && !second_clk_local_invert |-> rise_en != fall_en;
    endproperty
    a_edges: assert property (p_edges) else $error("edge strobes overlap"); // [RQ10]
    property p_sync_reset;
        sdr_sync_rst |=> !sdr_clr_q;
    endproperty
    a_sync_reset: assert property (p_sync_reset) else $error("sync reset failed"); // [RQ1]

    c_pipelined: cover property (rise_en && edge_mode == aligned_pipelined_mode);
    c_hold_end: cover property ($fell(holding));
    c_fifo_full: cover property (!pair_in_ready);
endmodule // dior_top

//--- common/dior_pkg.sv
// Shared constants and types for the pad-side dual-rate register block.
package dior_pkg;
    // Input dual-rate edge alignment modes.
    typedef enum logic [1:0] {
        split_edge_mode = 2'b00,
        aligned_edge_mode = 2'b01,
        aligned_pipelined_mode = 2'b10
    } dior_edge_mode_t;

    // Single-rate flip-flop variants.
    typedef enum logic [1:0] {
        ff_async_clear = 2'b00,
        ff_async_preset = 2'b01,
        ff_sync_reset = 2'b10,
        ff_sync_set = 2'b11
    } dior_ff_variant_t;

    // A captured input pair, rise sample beside fall sample.
    typedef struct packed {
        logic rise;
        logic fall;
    } dior_pair_t;

    // A pair of half-period values handed to an output path.
    typedef struct packed {
        logic first_half;
        logic second_half;
    } dior_halves_t;

    localparam int unsigned DIOR_SYNC_STAGES = 3;
    localparam int unsigned DIOR_FIFO_DEPTH = 8;
    localparam int unsigned DIOR_FIFO_WIDTH = 2;
    localparam logic [2:0] DIOR_HOLD_CYCLES = 3'h4;
    localparam logic [2:0] DIOR_HOLD_ZERO = 3'h0;
    localparam logic [2:0] DIOR_HOLD_STEP = 3'h1;
    localparam dior_edge_mode_t DIOR_MODE_RESET = split_edge_mode;
endpackage

//--- verification/dior_pad_model.sv
// Far-side pad device that drives the pad input and watches the driven pad line.
module dior_pad_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic tx_bit,
    output logic pad_in,
    input wire logic pad_out,
    input wire logic pad_oe,
    output logic rx_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Data leaves just after an edge and goes out as is, never inverted.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pad_in <= 1'b0;
        end else begin
            pad_in <= tx_bit;
        end
    end
    // A released line floats to the board pull-up, so stale data cannot pass.
    assign rx_level = pad_oe ? pad_out : 1'b1;
endmodule // dior_pad_model

//--- verification/testbench.sv
// Self-checking bench for the pad-side dual-rate register block.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dior_pkg::*;
    logic mclk, resetn, main_clk_local_invert, second_clk_local_invert, tx_bit;
    logic in_reg_reset, pair_ready, sdr_ce, sdr_sr, sdr_pad_in, output_set_reset;
    logic reset_output_value, reset_oe_value, ddr_clk_out, pad_in, rise_out, fall_out;
    logic pair_valid, pair_in_ready, sdr_q, pad_out, pad_oe, rx_level, rp, fp, rp0, ok;
    dior_edge_mode_t edge_mode;
    dior_ff_variant_t sdr_variant;
    dior_halves_t out_data, out_drive_en;
    dior_pair_t pair_data;
    int fail_count = 0;
    int n_checks = 0;
    int lat [2];

    // Block under test and the pad device on its far side.
    dior_top dior_top_i (.mclk(mclk), .resetn(resetn), .ddr_clk_out(ddr_clk_out),
        .main_clk_local_invert(main_clk_local_invert), .edge_mode(edge_mode),
        .second_clk_local_invert(second_clk_local_invert), .pad_in(pad_in),
        .in_reg_reset(in_reg_reset), .rise_out(rise_out), .fall_out(fall_out),
        .pair_data(pair_data), .pair_valid(pair_valid), .pair_ready(pair_ready),
        .pair_in_ready(pair_in_ready), .sdr_variant(sdr_variant), .sdr_ce(sdr_ce),
        .sdr_sr(sdr_sr), .sdr_pad_in(sdr_pad_in), .sdr_q(sdr_q), .out_data(out_data),
        .out_drive_en(out_drive_en), .output_set_reset(output_set_reset),
        .reset_output_value(reset_output_value), .reset_oe_value(reset_oe_value),
        .pad_out(pad_out), .pad_oe(pad_oe));
    dior_pad_model dior_pad_model_i (.mclk(mclk), .resetn(resetn), .tx_bit(tx_bit),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .rx_level(rx_level));

    // Free-running 100 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Compare helpers; case equality keeps an unknown from passing.
    task automatic chk(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_num(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic limit(input string what, input int n, input int lim);
        if (n >= lim) begin
            chk(what, 1'b1, 1'b0);
            print_verdict();
        end
    endtask
    // Waits n edges and lets their updates settle.
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Records the clock phase at which each capture output changes.
    task automatic measure(input dior_edge_mode_t m, input logic mi, input logic si);
        logic pr, pf, hr, hf;
        @(posedge mclk);
        edge_mode <= m;
        main_clk_local_invert <= mi;
        second_clk_local_invert <= si;
        tick(8);
        pr = rise_out;
        pf = fall_out;
        hr = 1'b0;
        hf = 1'b0;
        ok = 1'b1;
        for (int i = 0; i < 48; i++) begin
            @(posedge mclk);
            tx_bit <= i[2];
            #1;
            if (rise_out !== pr) begin
                ok = ok & (!hr | (rp === ddr_clk_out));
                rp = ddr_clk_out;
                hr = 1'b1;
            end
            if (fall_out !== pf) begin
                ok = ok & (!hf | (fp === ddr_clk_out));
                fp = ddr_clk_out;
                hf = 1'b1;
            end
            pr = rise_out;
            pf = fall_out;
        end
        ok = ok & hr & hf;
    endtask

    // Edge modes and clock inversion settings, judged by update phase.
    task automatic t_modes();
        measure(split_edge_mode, 1'b0, 1'b0);
        chk("split steady phases", 1'b1, ok);
        chk("split phases differ", 1'b1, rp ^ fp);
        rp0 = rp;
        measure(aligned_edge_mode, 1'b0, 1'b0);
        chk("aligned same phase", 1'b1, ok & (rp === fp));
        measure(aligned_pipelined_mode, 1'b0, 1'b0);
        chk("pipelined same phase", 1'b1, ok & (rp === fp));
        measure(split_edge_mode, 1'b1, 1'b0);
        chk("inverted rise phase", 1'b1, ok & (rp !== rp0));
        measure(split_edge_mode, 1'b0, 1'b1);
        chk("second clock phase", 1'b1, ok & (rp === rp0));
    endtask

    // The pipelined mode lags the aligned mode by one dual-rate cycle.
    task automatic t_latency();
        int n;
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            edge_mode <= (k == 0) ? aligned_edge_mode : aligned_pipelined_mode;
            tx_bit <= 1'b0;
            tick(12);
            n = 0;
            while (ddr_clk_out !== 1'b1 && n < 4) begin
                tick(1);
                n++;
            end
            limit("clock phase wait", n, 4);
            @(posedge mclk);
            tx_bit <= 1'b1;
            #1;
            n = 0;
            while (rise_out !== 1'b1 && n < 30) begin
                tick(1);
                n++;
            end
            limit("rise sample wait", n, 30);
            lat[k] = n;
        end
        chk_num("pipelined extra edges", 8'h02, 8'(lat[1] - lat[0]));
    endtask

    // Capture clear acts at once and releases on a capture edge.
    task automatic t_in_reset();
        @(posedge mclk);
        edge_mode <= split_edge_mode;
        tick(12);
        @(posedge mclk);
        in_reg_reset <= 1'b1;
        #1;
        chk("rise cleared", 1'b0, rise_out);
        chk("fall cleared", 1'b0, fall_out);
        @(posedge mclk);
        in_reg_reset <= 1'b0;
        tick(8);
        chk("rise after release", 1'b1, rise_out);
    endtask

    // Pairs fill the buffer while the fabric stalls, then drain.
    task automatic t_fifo();
        int n;
        @(posedge mclk);
        pair_ready <= 1'b0;
        #1;
        n = 0;
        while (pair_in_ready !== 1'b0 && n < 60) begin
            tick(1);
            n++;
        end
        limit("buffer full wait", n, 60);
        @(posedge mclk);
        pair_ready <= 1'b1;
        #1;
        n = 0;
        while (pair_valid === 1'b1 && n < 60) begin
            chk_num("popped pair", 8'h03, 8'(pair_data));
            tick(1);
            n++;
        end
        chk("buffer drained", 1'b0, pair_valid);
        chk("buffer space", 1'b1, pair_in_ready);
    endtask

    // Output halves and enable halves follow the clock halves.
    task automatic t_out();
        for (int k = 0; k < 2; k++) begin
            @(posedge mclk);
            out_data <= {~k[0], k[0]};
            out_drive_en <= {k[0], 1'b1};
            tick(6);
            repeat (6) begin
                chk("pad line", ddr_clk_out ^ k[0], rx_level);
                chk("pad data", ddr_clk_out ^ k[0], pad_out);
                chk("pad enable", k[0] | ~ddr_clk_out, pad_oe);
                tick(1);
            end
        end
    endtask

    // Forced level appears at once and holds for four rise strobes.
    task automatic t_sr();
        int n, t;
        logic prev;
        for (int v = 0; v < 2; v++) begin
            @(posedge mclk);
            reset_output_value <= v[0];
            reset_oe_value <= v[0];
            out_data <= {2{~v[0]}};
            out_drive_en <= {2{~v[0]}};
            tick(10);
            @(posedge mclk);
            output_set_reset <= 1'b1;
            #1;
            chk("pad forced", v[0], pad_out);
            chk("enable forced", v[0], pad_oe);
            tick(3);
            @(posedge mclk);
            output_set_reset <= 1'b0;
            #1;
            prev = ddr_clk_out;
            n = 0;
            t = 0;
            while (pad_out === v[0] && t < 20) begin
                tick(1);
                t++;
                n += (ddr_clk_out && !prev) ? 1 : 0;
                prev = ddr_clk_out;
            end
            limit("forced hold wait", t, 20);
            chk("hold strobes", 1'b1, n >= 4 && n <= 5);
        end
    endtask

    // Each single-rate variant: load, forced value and its timing, enable gating.
    task automatic t_sdr();
        logic f;
        for (int k = 0; k < 4; k++) begin
            f = k[0];
            @(posedge mclk);
            sdr_variant <= dior_ff_variant_t'(k[1:0]);
            sdr_pad_in <= ~f;
            sdr_ce <= 1'b1;
            tick(6);
            chk("sdr load", ~f, sdr_q);
            @(posedge mclk);
            sdr_sr <= 1'b1;
            #1;
            chk("sdr same cycle", k[1] ? ~f : f, sdr_q);
            tick(1);
            chk("sdr forced", f, sdr_q);
            @(posedge mclk);
            sdr_sr <= 1'b0;
            sdr_ce <= 1'b0;
            tick(6);
            chk("sdr enable off", f, sdr_q);
        end
    endtask

    // Main sequence: reset values, then every scenario in turn.
    initial begin
        resetn = 1'b0;
        main_clk_local_invert = 1'b0;
        second_clk_local_invert = 1'b0;
        edge_mode = split_edge_mode;
        tx_bit = 1'b0;
        in_reg_reset = 1'b0;
        pair_ready = 1'b1;
        sdr_variant = ff_async_clear;
        sdr_ce = 1'b0;
        sdr_sr = 1'b0;
        sdr_pad_in = 1'b0;
        out_data = 2'h0;
        out_drive_en = 2'h0;
        output_set_reset = 1'b0;
        reset_output_value = 1'b1;
        reset_oe_value = 1'b1;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        #1;
        chk("pad at reset", 1'b1, pad_out);
        chk("enable at reset", 1'b1, pad_oe);
        chk("rise at reset", 1'b0, rise_out);
        t_modes();
        t_latency();
        t_in_reset();
        t_fifo();
        t_out();
        t_sr();
        t_sdr();
        print_verdict();
    end

    // Hang guard for the whole run.
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        print_verdict();
    end
endmodule // testbench
